// file: hw/sct_top.sv
`include "sct_map.svh"

module sct_top
    import sct_pkg::*;
#(
    parameter int XTAL_HZ = `SCT_XTAL_HZ
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_crystal_pins,
    input wire logic i_transfer_frame_input,
    input wire logic i_serial_shift_clock,
    input wire logic i_serial_data_line,
    output logic o_serial_data_line,
    output logic o_serial_data_line_oe,
    output logic o_osc_enable,
    output logic o_standby,
    output logic o_write_lock,
    output sct_time_t o_time
);
    if (XTAL_HZ < 2)
    begin : g_bad_xtal
        $error("crystal rate too small for the prescaler");
    end

    localparam int PW = $clog2(XTAL_HZ);
    localparam logic [PW-1:0] PRESC_MAX = PW'(XTAL_HZ - 1);
    localparam logic [7:0] MSK [7] = '{`SCT_MSK_SEC, `SCT_MSK_MIN, `SCT_MSK_HOUR, `SCT_MSK_DATE,
        `SCT_MSK_MONTH, `SCT_MSK_WDAY, `SCT_MSK_YEAR};
    localparam logic [7:0] RST_V [7] = '{`SCT_RST_ZERO, `SCT_RST_ZERO, `SCT_RST_ZERO, `SCT_RST_ONE,
        `SCT_RST_ONE, `SCT_RST_ONE, `SCT_RST_ZERO};

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    logic [3:0] sync_q;
    logic xtal_d_ff;
    logic sclk_d_ff;

    sct_sync #(.W(4)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_d({i_crystal_pins, i_transfer_frame_input, i_serial_shift_clock, i_serial_data_line}),
        .o_q(sync_q)
    );

    wire xtal_s = sync_q[3];
    wire frame_s = sync_q[2];
    wire sclk_s = sync_q[1];
    wire sdi_s = sync_q[0];

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            xtal_d_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            xtal_d_ff <= xtal_s;
            sclk_d_ff <= sclk_s;
        end
    end

    // edges only come from host pulses; a still clock shifts nothing
    wire rise = sclk_s & ~sclk_d_ff;
    wire fall = ~sclk_s & sclk_d_ff;
    wire xrise = xtal_s & ~xtal_d_ff;

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    sct_st_t st_ff;
    logic [2:0] bit_ff;
    logic [2:0] idx_ff;
    logic burst_ff;
    logic [7:0] rx_ff;
    logic [7:0] tx_ff;
    logic sdo_ff;
    logic oe_ff;
    sct_wr_t wr_ff;
    logic [7:0] reg_view [8];

    wire [7:0] cmd_byte = {sdi_s, rx_ff[7:1]};
    wire byte_done = rise & (bit_ff == 3'h7);
    wire shifting_in = rise & ((st_ff == ST_CMD) | (st_ff == ST_WR));
    wire cmd_burst = ((cmd_byte | 8'h01) == `SCT_CMD_BURST_RD);
    wire cmd_single = (cmd_byte[7:4] == `SCT_CMD_SINGLE);
    wire cmd_ok = cmd_burst | cmd_single;
    wire [2:0] cmd_idx = cmd_burst ? 3'h0 : cmd_byte[3:1];
    wire [2:0] idx_inc = idx_ff + 3'h1;
    wire [2:0] rd_next = burst_ff ? idx_inc : idx_ff;
    wire cmd_end = (st_ff == ST_CMD) & byte_done;
    wire wr_end = (st_ff == ST_WR) & byte_done;
    wire rd_step = (st_ff == ST_RD) & fall;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_ff <= ST_CMD;
            bit_ff <= 3'h0;
            idx_ff <= 3'h0;
            burst_ff <= 1'b0;
            rx_ff <= 8'h00;
            tx_ff <= 8'h00;
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else if (!frame_s)
        begin
            st_ff <= ST_CMD;
            bit_ff <= 3'h0;
            burst_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else
        begin
            if (shifting_in)
            begin
                rx_ff <= cmd_byte;
                bit_ff <= bit_ff + 3'h1;
            end
            if (cmd_end)
            begin
                idx_ff <= cmd_idx;
                burst_ff <= cmd_burst;
                tx_ff <= reg_view[cmd_idx];
                st_ff <= !cmd_ok ? ST_IGN : (cmd_byte[0] ? ST_RD : ST_WR);
            end
            if (wr_end)
            begin
                idx_ff <= idx_inc;
                st_ff <= (burst_ff && idx_ff != 3'h7) ? ST_WR : ST_IGN;
            end
            if (rd_step)
            begin
                oe_ff <= 1'b1;
                sdo_ff <= tx_ff[0];
                bit_ff <= bit_ff + 3'h1;
                if (bit_ff == 3'h7)
                begin
                    idx_ff <= rd_next;
                    tx_ff <= reg_view[rd_next];
                end
                else
                begin
                    tx_ff <= {1'b0, tx_ff[7:1]};
                end
            end
        end
    end

    // write request waits one cycle so it lands cleanly in the counter update
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ff <= '0;
        end
        else
        begin
            wr_ff <= '{stb: wr_end & frame_s, burst: burst_ff, idx: idx_ff, data: cmd_byte};
        end
    end

    // ----------------------------------------
    // timebase
    // ----------------------------------------
    logic halt_ff;
    logic wp_ff;
    logic [PW-1:0] presc_ff;
    logic sec_tick_ff;
    logic pend_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            presc_ff <= '0;
            sec_tick_ff <= 1'b0;
            pend_ff <= 1'b0;
        end
        else
        begin
            sec_tick_ff <= xrise & ~halt_ff & (presc_ff == PRESC_MAX);
            pend_ff <= (sec_tick_ff | pend_ff) & wr_ff.stb;
            if (xrise && !halt_ff)
            begin
                presc_ff <= (presc_ff == PRESC_MAX) ? '0 : presc_ff + PW'(1);
            end
        end
    end

    // a tick that meets a write is held back one cycle rather than lost
    wire tick = (sec_tick_ff | pend_ff) & ~wr_ff.stb & ~halt_ff;

    // ----------------------------------------
    // calendar counters
    // ----------------------------------------
    logic [7:0] tk_ff [7];
    logic [7:0] inc_val [7];
    logic [7:0] inc_lo [7];
    logic [7:0] inc_hi [7];
    logic [7:0] inc_nxt [7];
    logic inc_wrap [7];
    logic c_en [7];
    logic [7:0] upd [7];

    wire wr_ok = wr_ff.stb & ((wr_ff.idx == `SCT_REG_WP) ? ~wr_ff.burst : ~wp_ff);
    wire h12 = tk_ff[2][`SCT_H12_BIT];
    wire pm = tk_ff[2][`SCT_PM_BIT];
    wire h_eleven = (tk_ff[2][4:0] == 5'h11);
    wire day_carry = h12 ? (h_eleven & pm) : inc_wrap[2];
    wire [7:0] hour_new = h12 ? {1'b1, 1'b0, pm ^ h_eleven, inc_nxt[2][4:0]} : {2'b00, inc_nxt[2][5:0]};
    wire [3:0] yr_u = tk_ff[6][3:0];
    wire leap = tk_ff[6][4] ? (yr_u == 4'h2 || yr_u == 4'h6)
        : (yr_u == 4'h0 || yr_u == 4'h4 || yr_u == 4'h8);
    wire [7:0] mon = tk_ff[4];
    wire short_mon = (mon == 8'h04) || (mon == 8'h06) || (mon == 8'h09) || (mon == 8'h11);
    wire [7:0] last_day = (mon == 8'h02) ? (leap ? 8'h29 : 8'h28) : (short_mon ? 8'h30 : 8'h31);

    assign inc_val = '{tk_ff[0], tk_ff[1], h12 ? {3'b000, tk_ff[2][4:0]} : {2'b00, tk_ff[2][5:0]},
        tk_ff[3], tk_ff[4], tk_ff[5], tk_ff[6]};
    assign inc_lo = '{8'h00, 8'h00, h12 ? 8'h01 : 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    assign inc_hi = '{8'h59, 8'h59, h12 ? 8'h12 : 8'h23, last_day, 8'h12, 8'h07, 8'h99};

    assign c_en[0] = tick;
    assign c_en[1] = c_en[0] & inc_wrap[0];
    assign c_en[2] = c_en[1] & inc_wrap[1];
    assign c_en[3] = c_en[2] & day_carry;
    assign c_en[4] = c_en[3] & inc_wrap[3];
    assign c_en[5] = c_en[3];
    assign c_en[6] = c_en[4] & inc_wrap[4];

    for (genvar k = 0; k < 7; k++)
    begin : g_field
        sct_bcd_inc u_inc (
            .i_val(inc_val[k]),
            .i_lo(inc_lo[k]),
            .i_hi(inc_hi[k]),
            .o_nxt(inc_nxt[k]),
            .o_wrap(inc_wrap[k])
        );
        wire hit = wr_ok & (wr_ff.idx == 3'(k));
        assign upd[k] = (k == 2) ? hour_new : inc_nxt[k];
        wire [7:0] nxt_tk = hit ? (wr_ff.data & MSK[k]) : (c_en[k] ? upd[k] : tk_ff[k]);

        always_ff @(posedge i_sys_clk or negedge i_rst_n)
        begin
            if (!i_rst_n)
                tk_ff[k] <= RST_V[k];
            else
                tk_ff[k] <= nxt_tk;
        end
    end

    wire hit_halt = wr_ok & (wr_ff.idx == `SCT_REG_SEC);
    wire hit_wp = wr_ok & (wr_ff.idx == `SCT_REG_WP);

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            halt_ff <= `SCT_RST_HALT;
            wp_ff <= `SCT_RST_WP;
        end
        else
        begin
            halt_ff <= hit_halt ? wr_ff.data[`SCT_HALT_BIT] : halt_ff;
            wp_ff <= hit_wp ? wr_ff.data[`SCT_WP_BIT] : wp_ff;
        end
    end

    for (genvar k = 1; k < 7; k++)
    begin : g_view
        assign reg_view[k] = tk_ff[k];
    end
    assign reg_view[0] = {halt_ff, tk_ff[0][6:0]};
    assign reg_view[7] = {wp_ff, 7'h00};

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_serial_data_line = sdo_ff;
    assign o_serial_data_line_oe = oe_ff;
    assign o_osc_enable = ~halt_ff;
    assign o_standby = halt_ff;
    assign o_write_lock = wp_ff;
    assign o_time = {tk_ff[0], tk_ff[1], tk_ff[2], tk_ff[3], tk_ff[4], tk_ff[5], tk_ff[6]};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_oe_release: assert property (!frame_s |=> !oe_ff && bit_ff == 3'h0)
        else $error("line not released after frame drop");
    a_oe_read_only: assert property (oe_ff |-> st_ff == ST_RD)
        else $error("data line driven outside read phase");
    a_halt_hold: assert property (halt_ff && !wr_ff.stb |=> $stable(o_time))
        else $error("counters moved while halted");
    a_halt_standby: assert property (halt_ff && $past(halt_ff) |-> !sec_tick_ff && o_standby)
        else $error("timebase ticking in standby");
    a_wp_blocks: assert property (wr_ff.stb && wp_ff && wr_ff.idx == 3'h0 |=> $stable(halt_ff))
        else $error("locked write reached seconds register");
    a_sec_roll: assert property (c_en[0] && tk_ff[0] == 8'h59
        |=> tk_ff[0] == 8'h00 && tk_ff[1] != $past(tk_ff[1]))
        else $error("seconds did not carry into minutes");
    a_leap_feb: assert property (c_en[3] && mon == 8'h02 && tk_ff[3] == 8'h28 && leap |=> tk_ff[3] == 8'h29)
        else $error("leap February skipped day 29");
    a_month_end: assert property (c_en[3] && tk_ff[3] == last_day |=> tk_ff[3] == 8'h01)
        else $error("date did not roll at month end");
    a_h12_roll: assert property (c_en[2] && h12 && tk_ff[2][4:0] == 5'h12 |=> tk_ff[2][4:0] == 5'h01)
        else $error("12-hour form did not roll 12 to 1");
    a_tick_rate: assert property (sec_tick_ff |-> $past(presc_ff) == PRESC_MAX)
        else $error("second tick at wrong crystal count");
    a_lsb_first: assert property (shifting_in && bit_ff == 3'h0 && frame_s |=> rx_ff[7] == $past(sdi_s))
        else $error("first bit not shifted in at the top");
    a_burst_cmd: assert property (frame_s && cmd_end && cmd_burst |=> idx_ff == 3'h0 && burst_ff)
        else $error("burst did not start at register zero");
    a_cmd_decode: assert property (frame_s && cmd_end && cmd_single
        |=> idx_ff == $past(cmd_byte[3:1]) && ((st_ff == ST_RD) == $past(cmd_byte[0])))
        else $error("command byte decoded wrongly");
    a_single_stop: assert property (frame_s && wr_end && !burst_ff |=> st_ff == ST_IGN)
        else $error("single write took more than one byte");
    a_no_pulse: assert property (frame_s && !rise && !fall ##1 frame_s
        |-> $stable(bit_ff) && $stable(rx_ff))
        else $error("shift without host clock pulse");

    c_burst_read: cover property (frame_s && cmd_end && cmd_burst && cmd_byte[0]);
    c_single_write: cover property (wr_ok && !wr_ff.burst);
    c_day_roll: cover property (c_en[3]);
    c_halted: cover property (hit_halt && wr_ff.data[7]);
endmodule

// file: hw/sct_map.svh
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH

// ----------------------------------------
// register indices and command bytes
// ----------------------------------------
`define SCT_REG_SEC 3'h0
`define SCT_REG_HOUR 3'h2
`define SCT_REG_MONTH 3'h4
`define SCT_REG_WP 3'h7
`define SCT_CMD_BURST_WR 8'hBE
`define SCT_CMD_BURST_RD 8'hBF
`define SCT_CMD_SINGLE 4'h8

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define SCT_HALT_BIT 7
`define SCT_WP_BIT 7
`define SCT_H12_BIT 7
`define SCT_PM_BIT 5
`define SCT_MSK_SEC 8'h7F
`define SCT_MSK_MIN 8'h7F
`define SCT_MSK_HOUR 8'hBF
`define SCT_MSK_DATE 8'h3F
`define SCT_MSK_MONTH 8'h1F
`define SCT_MSK_WDAY 8'h07
`define SCT_MSK_YEAR 8'hFF

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SCT_RST_HALT 1'b1
`define SCT_RST_WP 1'b1
`define SCT_RST_ZERO 8'h00
`define SCT_RST_ONE 8'h01
`define SCT_XTAL_HZ 32768
`endif

// file: hw/sct_pkg.sv
package sct_pkg;
    typedef enum logic [3:0] {
        ST_CMD = 4'b0001,
        ST_WR = 4'b0010,
        ST_RD = 4'b0100,
        ST_IGN = 4'b1000
    } sct_st_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] wday;
        logic [7:0] year;
    } sct_time_t;

    typedef struct packed {
        logic stb;
        logic burst;
        logic [2:0] idx;
        logic [7:0] data;
    } sct_wr_t;
endpackage

// file: hw/sct_sync.sv
module sct_sync
    import sct_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    if (W < 1)
    begin : g_bad_w
        $error("sct_sync width must be at least one");
    end

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end

    assign o_q = sync_ff;
endmodule

// file: hw/sct_bcd_inc.sv
module sct_bcd_inc
    import sct_pkg::*;
(
    input wire logic [7:0] i_val,
    input wire logic [7:0] i_lo,
    input wire logic [7:0] i_hi,
    output logic [7:0] o_nxt,
    output logic o_wrap
);
    // values written by the host at or above the high bound also wrap to the low bound
    wire at_top = (i_val >= i_hi);
    wire units_nine = (i_val[3:0] >= 4'h9);
    wire [3:0] tens_up = i_val[7:4] + 4'h1;
    wire [3:0] units_up = i_val[3:0] + 4'h1;

    assign o_wrap = at_top;
    assign o_nxt = at_top ? i_lo : (units_nine ? {tens_up, 4'h0} : {i_val[7:4], units_up});
endmodule

// file: sim/sct_host.sv
module sct_host
(
    input wire logic i_sys_clk,
    input wire logic i_dev_d,
    input wire logic i_dev_oe,
    output logic o_frame,
    output logic o_sclk,
    output logic o_line,
    output int o_clash
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hd = 1'b0;
    logic hoe = 1'b0;
    logic last = 1'b0;
    logic [7:0] wq[$];
    logic [7:0] rq[$];

    initial
    begin
        o_frame = 1'b0;
        o_sclk = 1'b0;
        o_clash = 0;
    end

    // no pull on the wire: undriven it shows the inverse of the last level
    assign o_line = i_dev_oe ? i_dev_d : (hoe ? hd : ~last);

    always @(posedge i_sys_clk)
    begin
        if (i_dev_oe | hoe)
            last <= o_line;
        if (i_dev_oe & hoe)
            o_clash <= o_clash + 1;
    end

    // data changes at the fall, so it is settled long before the rise
    task automatic put_bit(input logic b);
        o_sclk = 1'b0;
        hoe = 1'b1;
        hd = b;
        #32;
        o_sclk = 1'b1;
        #32;
    endtask

    task automatic get_bit(output logic b);
        o_sclk = 1'b0;
        hoe = 1'b0;
        #32;
        b = o_line;
        o_sclk = 1'b1;
        #32;
    endtask

    task automatic xfer(input logic [7:0] cmd, input int n, input int cut);
        logic [7:0] v;
        o_frame = 1'b1;
        #40;
        for (int i = 0; i < 8; i++)
            put_bit(cmd[i]);
        for (int k = 0; k < n; k++)
        begin
            if (cmd[0])
            begin
                for (int i = 0; i < 8; i++)
                    get_bit(v[i]);
                rq.push_back(v);
            end
            else
            begin
                v = wq.pop_front();
                for (int i = 0; i < 8; i++)
                    put_bit(v[i]);
            end
        end
        for (int i = 0; i < cut; i++)
            put_bit(1'b1);
        o_sclk = 1'b0;
        hoe = 1'b0;
        o_frame = 1'b0;
        #40;
    endtask
endmodule

// file: sim/sct_top_tb_top.sv
`include "sct_map.svh"

module sct_top_tb_top
    import sct_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int XT = 4;
    localparam logic [7:0] MSK [7] = '{`SCT_MSK_SEC, `SCT_MSK_MIN, `SCT_MSK_HOUR, `SCT_MSK_DATE,
        `SCT_MSK_MONTH, `SCT_MSK_WDAY, `SCT_MSK_YEAR};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic xt = 1'b0;
    logic frame, sclk, line, dev_d, dev_oe, osc_en, stby, wlock, halt, lock;
    logic oe_seen = 1'b0;
    sct_time_t tm;
    int clash;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pre = 0;
    logic [31:0] seed = 32'h00000049;
    logic [7:0] r[7];
    logic [7:0] vec [3][8];

    sct_top #(.XTAL_HZ(XT)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_crystal_pins(xt),
        .i_transfer_frame_input(frame), .i_serial_shift_clock(sclk), .i_serial_data_line(line),
        .o_serial_data_line(dev_d), .o_serial_data_line_oe(dev_oe), .o_osc_enable(osc_en),
        .o_standby(stby), .o_write_lock(wlock), .o_time(tm));
    sct_host HOST (.i_sys_clk(clk), .i_dev_d(dev_d), .i_dev_oe(dev_oe), .o_frame(frame),
        .o_sclk(sclk), .o_line(line), .o_clash(clash));

    always #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (dev_oe === 1'b1)
            oe_seen = 1'b1;
        if (cycles == 40000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic int b2i(input logic [7:0] b);
        return b[7:4] * 10 + b[3:0];
    endfunction

    function automatic logic [7:0] i2b(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction

    // reference calendar: one second step on decimal integers
    task automatic advance();
        int s, mi, h, d, mo, w, y, dim, c, nd;
        logic pm;
        logic [7:0] hb;
        s = b2i(r[0]) + 1;
        mi = b2i(r[1]);
        h = b2i(r[2] & (r[2][7] ? 8'h1F : 8'h3F));
        pm = r[2][5];
        d = b2i(r[3]);
        mo = b2i(r[4]);
        w = r[5];
        y = b2i(r[6]);
        c = (s == 60);
        s = c ? 0 : s;
        mi += c;
        c = (mi == 60);
        mi = c ? 0 : mi;
        h += c;
        if (r[2][7])
        begin
            nd = (c && h == 12 && pm);
            if (c && h == 12)
                pm = ~pm;
            h = (h == 13) ? 1 : h;
        end
        else
        begin
            nd = (h == 24);
            h = nd ? 0 : h;
        end
        if (nd)
        begin
            w = (w == 7) ? 1 : w + 1;
            d++;
        end
        dim = (mo == 2) ? ((y % 4 == 0) ? 29 : 28) : (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
        if (d > dim)
        begin
            d = 1;
            mo++;
        end
        if (mo == 13)
        begin
            mo = 1;
            y = (y + 1) % 100;
        end
        r[0] = i2b(s);
        r[1] = i2b(mi);
        hb = i2b(h);
        r[2] = r[2][7] ? {2'b10, pm, hb[4:0]} : hb;
        r[3] = i2b(d);
        r[4] = i2b(mo);
        r[5] = 8'(w);
        r[6] = i2b(y);
    endtask

    task automatic cmp_state();
        check("time", tm, {r[0], r[1], r[2], r[3], r[4], r[5], r[6]});
        check("standby", stby, halt);
        check("osc", osc_en, !halt);
        check("lock", wlock, lock);
    endtask

    task automatic mwrite(input int idx, input logic [7:0] v, input logic burst);
        if (idx == 7)
        begin
            if (!burst)
                lock = v[7];
        end
        else if (!lock)
        begin
            r[idx] = v & MSK[idx];
            if (idx == 0)
                halt = v[7];
        end
    endtask

    function automatic logic [7:0] mread(input int idx);
        return (idx == 0) ? {halt, r[0][6:0]} : (idx == 7) ? {lock, 7'h00} : r[idx];
    endfunction

    task automatic wr(input logic [2:0] idx, input logic [7:0] v);
        HOST.wq.push_back(v);
        HOST.xfer({4'h8, idx, 1'b0}, 1, 0);
        mwrite(idx, v, 1'b0);
        cmp_state();
    endtask

    task automatic rd(input logic [2:0] idx, input logic burst, input int n);
        HOST.rq.delete();
        HOST.xfer(burst ? `SCT_CMD_BURST_RD : {4'h8, idx, 1'b1}, n, 0);
        for (int k = 0; k < n; k++)
            check("read", HOST.rq[k], mread(burst ? k % 8 : idx));
        check("oe", dev_oe, 1'b0);
    endtask

    // crystal edges only between frames, so no write meets a tick
    task automatic xtal(input int n);
        repeat (n)
        begin
            xt = 1'b1;
            if (!halt)
            begin
                pre++;
                if (pre == XT)
                begin
                    pre = 0;
                    advance();
                end
            end
            #100;
            xt = 1'b0;
            #100;
        end
        cmp_state();
    endtask

    initial
    begin
        r = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        halt = 1'b1;
        lock = 1'b1;
        vec[0] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h07, 8'h00, 8'h80};
        vec[1] = '{8'h59, 8'h59, 8'hB1, 8'h28, 8'h02, 8'h03, 8'h01, 8'h80};
        vec[2] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h05, 8'h99, 8'h80};
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        cmp_state();
        wr(3'h0, 8'h00);
        rd(3'h7, 1'b0, 1);
        wr(3'h7, 8'h00);
        wr(3'h0, 8'h30);
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            wr(3'h6, i2b(seed % 100));
            rd(3'h6, 1'b0, 2);
        end
        for (int t = 0; t < 3; t++)
        begin
            for (int i = 0; i < 8; i++)
                HOST.wq.push_back(vec[t][i]);
            HOST.xfer(`SCT_CMD_BURST_WR, 8, 0);
            for (int i = 0; i < 8; i++)
                mwrite(i, vec[t][i], 1'b1);
            cmp_state();
            xtal(XT - 1);
            xtal(1);
            rd(3'h0, 1'b1, 9);
        end
        HOST.xfer(8'h82, 0, 4);
        cmp_state();
        check("oe", dev_oe, 1'b0);
        oe_seen = 1'b0;
        HOST.xfer(8'h93, 1, 0);
        check("oe seen", oe_seen, 1'b0);
        wr(3'h0, 8'h80);
        xtal(2 * XT);
        rd(3'h0, 1'b0, 1);
        wr(3'h7, 8'h80);
        wr(3'h1, 8'h12);
        check("clash", clash, 0);
        summarize();
    end
endmodule
